//--- shared/p9gp_defs.vh
// constants for the port nine gpio and lcd segment pin multiplexer
`ifndef P9GP_DEFS_VH
`define P9GP_DEFS_VH

// ==================================================
// register byte addresses
`define P9GP_ADR_DATA      4'h0
`define P9GP_ADR_DIR       4'h4
`define P9GP_ADR_LCDCTL    4'h8
`define P9GP_ADR_PINS      4'hC

// ==================================================
// field positions of the lcd port control register
`define P9GP_SGS_LSB       0
`define P9GP_SGS_MSB       3
`define P9GP_SGX_BIT       4

// ==================================================
// reset values, fixed read values and the gpio segment select code
`define P9GP_DATA_RST      8'h00
`define P9GP_DIR_RST       8'h00
`define P9GP_LCDCTL_RST    5'h00
`define P9GP_DIR_READ      8'hFF
`define P9GP_SGS_GPIO      4'h0

// ==================================================
// operating mode codes on the mode input
`define P9GP_MODE_ACTIVE   3'h0
`define P9GP_MODE_SUBACT   3'h1
`define P9GP_MODE_SLEEP    3'h2
`define P9GP_MODE_SUBSLEEP 3'h3
`define P9GP_MODE_WATCH    3'h4
`define P9GP_MODE_STANDBY  3'h5

`endif

//--- verif/p9gp_monitor.sv
// assertion checker for the port nine pin multiplexer
`timescale 1ns/100ps
module p9gp_monitor (
	input wire        clk_i,
	input wire        rstn_i,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [3:0]  wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire [2:0]  power_mode_i,
	input wire [7:0]  lcd_segment_out_i,
	input wire        ext_driver_clock_one_i,
	input wire        ext_driver_clock_two_i,
	input wire        ext_driver_data_i,
	input wire        ext_driver_alt_i,
	input wire [7:0]  port_nine_pin_o,
	input wire [7:0]  port_nine_pin_oe_n_o
);
// ==========
// shadow registers; bench drops sel only on data writes, which are not shadowed
reg  [7:0] dir;
reg  [4:0] ctl;
wire [7:0] po  = port_nine_pin_o;
wire [7:0] oe  = port_nine_pin_oe_n_o;
wire       act = power_mode_i < 3'h2 || power_mode_i > 3'h5;
wire       gp  = ctl[3:0] == 4'h0;
always @(posedge clk_i or negedge rstn_i) begin
	if (!rstn_i) begin
		dir <= 8'h00;
		ctl <= 5'h00;
	end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o) begin
		if (wb_adr_i == 4'h4) dir <= wb_dat_i[7:0];
		if (wb_adr_i == 4'h8) ctl <= wb_dat_i[4:0];
	end
end
// ==========
// properties
default clocking cb @(posedge clk_i);
endclocking
default disable iff (!rstn_i);
rst_float_a: assert property ($rose(rstn_i) |-> oe == 8'hFF)
	else $error("pins driven at reset");
dir_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h4 |->
	wb_dat_o[7:0] == 8'hFF) else $error("direction read");
standby_a: assert property (power_mode_i == 3'h5 |=> oe == 8'hFF)
	else $error("standby drive");
pin_hold_a: assert property (!act && power_mode_i != 3'h5 |=> $stable({po, oe}))
	else $error("hold moved");
seg_drive_a: assert property (act && !gp |=>
	po == $past(lcd_segment_out_i) && oe == 8'h00) else $error("segment drive");
ext_drive_a: assert property (act && gp && ctl[4] |=> po[7:4] == $past({
	ext_driver_clock_one_i, ext_driver_clock_two_i, ext_driver_data_i, ext_driver_alt_i})
	&& oe[7:4] == 4'h0) else $error("driver pins");
gpio_dir_a: assert property (act && gp && !ctl[4] |=> oe == ~$past(dir))
	else $error("gpio direction");
low_gpio_a: assert property (act && gp |=> oe[3:0] == ~$past(dir[3:0]))
	else $error("low pins");
ext_mode_c: cover property (act && gp && ctl[4]);
standby_c: cover property (power_mode_i == 3'h5);
seg_mode_c: cover property (act && !gp);
endmodule // p9gp_monitor
bind p9gp_top p9gp_monitor u_mon (.*);

//--- verif/p9gp_pad_model.sv
// pads: a released pad follows the outside source
`timescale 1ns/100ps
module p9gp_pad_model (
	input  wire [7:0] pin_i,
	input  wire [7:0] oe_n_i,
	input  wire [7:0] far_i,
	output wire [7:0] level_o
);
assign level_o = (oe_n_i & far_i) | (~oe_n_i & pin_i);
endmodule // p9gp_pad_model

//--- verif/test_p9gp_top.sv
// self-checking bench for the port nine pin multiplexer
`timescale 1ns/100ps
module test_p9gp_top;
reg         clk_i = 1'b0;
reg         rstn_i = 1'b0;
reg         cyc = 1'b0;
reg         we = 1'b0;
reg  [3:0]  adr = 4'h0;
reg  [7:0]  wd = 8'h00;
reg  [2:0]  mode = 3'h0;
reg  [7:0]  lcd_segment_out = 8'h5A;
reg  [3:0]  drv = 4'hA;
reg  [3:0]  sel = 4'hF;
wire [31:0] rdat;
wire        ack;
wire [7:0]  po;
wire [7:0]  oen;
wire [7:0]  pi;
int         fails = 0;
int         n_checks = 0;
always #20 clk_i = ~clk_i;
p9gp_top u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
	.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i({24'h000000, wd}), .wb_dat_o(rdat),
	.wb_ack_o(ack), .power_mode_i(mode), .lcd_segment_out_i(lcd_segment_out),
	.ext_driver_clock_one_i(drv[3]), .ext_driver_clock_two_i(drv[2]),
	.ext_driver_data_i(drv[1]), .ext_driver_alt_i(drv[0]), .port_nine_pin_i(pi),
	.port_nine_pin_o(po), .port_nine_pin_oe_n_o(oen));
p9gp_pad_model u_pad (.pin_i(po), .oe_n_i(oen), .far_i(8'hA5), .level_o(pi));
task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
	n_checks++;
	if (g !== e) begin
		fails++;
		$display("[ERR] %s expected %h seen %h", nm, e, g);
	end
endtask
task wb(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
	int n;
	n = 0;
	@(posedge clk_i);
	cyc <= 1'b1;
	we <= w;
	adr <= a;
	wd <= d;
	do begin
		@(posedge clk_i);
		n++;
	end while (ack !== 1'b1 && n < 20);
	q = rdat[7:0];
	cyc <= 1'b0;
	chk("ack", 8'h01, {7'h00, ack});
endtask
task wr(input logic [3:0] a, input logic [7:0] d);
	logic [7:0] q;
	wb(1'b1, a, d, q);
endtask
task rdc(input string nm, input logic [3:0] a, input logic [7:0] e);
	logic [7:0] q;
	wb(1'b0, a, 8'h00, q);
	chk(nm, e, q);
endtask
// pins settle one edge after their cause; oe_n is compared on every bit, pin values only on driven bits
task pins(input logic [7:0] eo, input logic [7:0] ev);
	repeat (2) @(posedge clk_i);
	#1;
	chk("oe_n", eo, oen);
	chk("pin", ev & ~eo, po & ~eo);
endtask
task t_gpio;
	wr(4'h0, 8'h3C);
	wr(4'h4, 8'hF0);
	pins(8'h0F, 8'h30);
	rdc("data", 4'h0, 8'h35);
	rdc("dir", 4'h4, 8'hFF);
	rdc("pins", 4'hC, 8'h35);
endtask
task t_seg;
	for (int i = 1; i < 16; i += 7) begin
		wr(4'h8, {3'h0, i[0], i[3:0]});
		pins(8'h00, 8'h5A);
	end
endtask
task t_ext;
	wr(4'h8, 8'h10);
	pins(8'h0F, 8'hA0);
	@(posedge clk_i);
	drv <= 4'h5;
	wr(4'h4, 8'h0F);
	pins(8'h00, 8'h5C);
endtask
task t_modes;
	wr(4'h8, 8'h01);
	for (int m = 2; m < 6; m++) begin
		@(posedge clk_i);
		mode <= m[2:0];
		lcd_segment_out <= 8'h0F;
		pins(m == 5 ? 8'hFF : 8'h00, 8'h5A);
	end
	@(posedge clk_i);
	mode <= 3'h1;
	pins(8'h00, 8'h0F);
endtask
task t_rst;
	wr(4'h8, 8'h00);
	wr(4'h0, 8'h55);
	wr(4'h4, 8'hFF);
	@(posedge clk_i);
	rstn_i <= 1'b0;
	#1;
	chk("oe_n", 8'hFF, oen);
	repeat (2) @(posedge clk_i);
	rstn_i <= 1'b1;
	pins(8'hFF, 8'h00);
	rdc("data", 4'h0, 8'hA5);
	wr(4'h4, 8'hFF);
	rdc("data", 4'h0, 8'h00);
	// a write without the low byte lane must leave the latch alone
	sel <= 4'hE;
	wr(4'h0, 8'hFF);
	sel <= 4'hF;
	rdc("lane", 4'h0, 8'h00);
	rdc("unmapped", 4'h2, 8'h00);
endtask
task stop_test;
	$display("checks %0d mismatches %0d", n_checks, fails);
	if (fails == 0 && n_checks > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
endtask
initial begin
	repeat (2) @(posedge clk_i);
	rstn_i <= 1'b1;
	t_gpio();
	t_seg();
	t_ext();
	t_modes();
	t_rst();
	stop_test();
end
// whole run is well under 1000 cycles
initial begin
	#100000;
	fails++;
	stop_test();
end
endmodule // test_p9gp_top

//--- verilog/p9gp_pin_cell.v
// one port pin: function select, hold and float per operating mode
`timescale 1ns/100ps

module p9gp_pin_cell (
	input  wire clk_i,
	input  wire rstn_i,
	input  wire hold_i,
	input  wire standby_i,
	input  wire gpio_sel_i,
	input  wire ext_sel_i,
	input  wire dir_i,
	input  wire latch_i,
	input  wire seg_i,
	input  wire ext_i,
	output wire pin_o,
	output wire pin_oe_n_o
);

	reg pin_q;
	reg oe_n_q;
	reg next_pin;
	reg next_oe_n;

	// ==================================================
	// function select
	always @* begin
		if (gpio_sel_i) begin
			next_pin  = latch_i;
			next_oe_n = ~dir_i;
		end else if (ext_sel_i) begin
			next_pin  = ext_i;
			next_oe_n = 1'b0;
		end else begin
			next_pin  = seg_i;          // direction ignored here
			next_oe_n = 1'b0;
		end
	end

	// ==================================================
	// pin flops; sleep-type modes freeze them, standby floats the pin
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pin_q  <= 1'b0;
			oe_n_q <= 1'b1;
		end else if (standby_i) begin
			oe_n_q <= 1'b1;
		end else if (!hold_i) begin
			pin_q  <= next_pin;
			oe_n_q <= next_oe_n;
		end
	end

	assign pin_o      = pin_q;
	assign pin_oe_n_o = oe_n_q;

endmodule // p9gp_pin_cell

//--- verilog/p9gp_top.v
// port nine gpio with lcd segment and external driver pin sharing
`timescale 1ns/100ps
`include "p9gp_defs.vh"

module p9gp_top (
	input  wire        clk_i,
	input  wire        rstn_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [3:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output wire        wb_ack_o,
	input  wire [2:0]  power_mode_i,
	input  wire [7:0]  lcd_segment_out_i,
	input  wire        ext_driver_clock_one_i,
	input  wire        ext_driver_clock_two_i,
	input  wire        ext_driver_data_i,
	input  wire        ext_driver_alt_i,
	input  wire [7:0]  port_nine_pin_i,
	output wire [7:0]  port_nine_pin_o,
	output wire [7:0]  port_nine_pin_oe_n_o
);

	reg  [7:0]  pin_data_latch_reg;
	reg  [7:0]  pin_direction_reg;
	reg  [4:0]  lcd_port_control_reg;
	reg  [31:0] next_dat;
	wire        take;
	wire        wr_en;
	wire        gpio_sel;
	wire        ext_sel;
	wire        hold;
	wire        standby;
	wire [3:0]  segment_select_field;
	wire        driver_extension_select;
	wire [3:0]  ext_sig;
	wire [7:0]  ext_vec;
	wire [7:0]  ext_en;
	wire [7:0]  port_read;

	// ==================================================
	// bus handshake
	p9gp_wb_ack u_ack (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.cyc_i  (wb_cyc_i),
		.stb_i  (wb_stb_i),
		.ack_o  (wb_ack_o),
		.take_o (take)
	);

	// only the low byte lane carries register data
	assign wr_en = take & wb_we_i & wb_sel_i[0];

	// ==================================================
	// register writes
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pin_data_latch_reg   <= `P9GP_DATA_RST;
			pin_direction_reg    <= `P9GP_DIR_RST;
			lcd_port_control_reg <= `P9GP_LCDCTL_RST;
		end else if (wr_en) begin
			if (wb_adr_i == `P9GP_ADR_DATA) begin
				pin_data_latch_reg <= wb_dat_i[7:0];
			end else if (wb_adr_i == `P9GP_ADR_DIR) begin
				pin_direction_reg <= wb_dat_i[7:0];
			end else if (wb_adr_i == `P9GP_ADR_LCDCTL) begin
				lcd_port_control_reg <= wb_dat_i[4:0];
			end
		end
	end

	// ==================================================
	// register reads
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_rd
			// output pins report the latch, inputs the live level
			assign port_read[g] = pin_direction_reg[g] ? pin_data_latch_reg[g] :
			                      port_nine_pin_i[g];
		end
	endgenerate

	always @* begin
		next_dat = 32'h00000000;
		if (wb_adr_i == `P9GP_ADR_DATA) begin
			next_dat[7:0] = port_read;
		end else if (wb_adr_i == `P9GP_ADR_DIR) begin
			next_dat[7:0] = `P9GP_DIR_READ;
		end else if (wb_adr_i == `P9GP_ADR_LCDCTL) begin
			next_dat[4:0] = lcd_port_control_reg;
		end else if (wb_adr_i == `P9GP_ADR_PINS) begin
			next_dat[7:0] = port_nine_pin_i;
		end
	end

	// unmapped addresses still ack, reading zero
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (take & ~wb_we_i) begin
			wb_dat_o <= next_dat;
		end
	end

	// ==================================================
	// function and mode decode
	assign segment_select_field    = lcd_port_control_reg[`P9GP_SGS_MSB:`P9GP_SGS_LSB];
	assign driver_extension_select = lcd_port_control_reg[`P9GP_SGX_BIT];
	assign gpio_sel = (segment_select_field == `P9GP_SGS_GPIO);
	// extension is only reachable with the field at zero; nonzero field wins
	assign ext_sel  = gpio_sel & driver_extension_select;

	assign hold    = (power_mode_i == `P9GP_MODE_SLEEP) |
	                 (power_mode_i == `P9GP_MODE_SUBSLEEP) |
	                 (power_mode_i == `P9GP_MODE_WATCH);
	assign standby = (power_mode_i == `P9GP_MODE_STANDBY);

	// upper pins carry clock one, clock two, serial data, alternating
	assign ext_sig = {ext_driver_clock_one_i, ext_driver_clock_two_i,
	                  ext_driver_data_i, ext_driver_alt_i};
	assign ext_vec = {ext_sig, 4'h0};
	assign ext_en  = {{4{ext_sel}}, 4'h0};

	// ==================================================
	// pin cells; lcd_segment_out_i[n] is segment n+33
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_pin
			p9gp_pin_cell u_cell (
				.clk_i      (clk_i),
				.rstn_i     (rstn_i),
				.hold_i     (hold),
				.standby_i  (standby),
				.gpio_sel_i (gpio_sel & ~ext_en[g]),
				.ext_sel_i  (ext_en[g]),
				.dir_i      (pin_direction_reg[g]),
				.latch_i    (pin_data_latch_reg[g]),
				.seg_i      (lcd_segment_out_i[g]),
				.ext_i      (ext_vec[g]),
				.pin_o      (port_nine_pin_o[g]),
				.pin_oe_n_o (port_nine_pin_oe_n_o[g])
			);
		end
	endgenerate

endmodule // p9gp_top

//--- verilog/p9gp_wb_ack.v
// wishbone classic single-cycle acknowledge generator
`timescale 1ns/100ps

module p9gp_wb_ack (
	input  wire clk_i,
	input  wire rstn_i,
	input  wire cyc_i,
	input  wire stb_i,
	output wire ack_o,
	output wire take_o
);

	reg ack;

	// ==================================================
	// one-cycle ack; dropped the cycle after so a held request is not taken twice
	assign take_o = cyc_i & stb_i & ~ack;
	assign ack_o  = ack;

	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ack <= 1'b0;
		end else begin
			ack <= take_o;
		end
	end

endmodule // p9gp_wb_ack
